// ### hw/standby_pkg.sv
// Purpose: constants for the standby and reset sequencer
// Assumes: byte framing is done by the host-interface front end
// Notes: how the sequencer behaves is listed below
// How it works
// - stop command arms standby; entered when busy clears
// - standby gates clock to LCD timing blocks
// - standby forces write mode, auto-increment step
// - standby ends on full byte or reset fall
// - serial mode: ends at eighth shift clock rise
// - parallel mode: ends at second strobe rise
// - serial addressed: skip address byte after select
// - reset in standby: outputs reset-like, memory kept
// - reset loads address compare value with zero
// - reset busy: low if strap zero and selected
// - reset halts processing and driver transfers
// - reset drives all outputs to level three
// - reset selects write, auto-increment, pointer zero
// - reset sets multiplex field to zero
// - reset sets frame divider to two-to-fourteen
// - reset clears byte transfer counter
// - reset outside standby invalidates memory; inside holds
// - reset fall samples interface selection straps
// - after reset display blanked, chip zero selected
// - reset fall in standby ends it, memory kept
// - parallel strap high wins; else enable selects addressing
package standby_pkg;
    localparam logic [1:0] STEP_INC = 2'h0;
    localparam logic [1:0] MODE_WRITE = 2'h1;
    localparam logic [1:0] MODE_READ = 2'h0;
    localparam logic [6:0] POINTER_RESET = 7'h00;
    localparam logic [2:0] MULTIPLEX_RESET = 3'h0;
    localparam logic [2:0] FRAME_DIV_RESET = 3'h0;
    localparam logic [1:0] COMPARE_RESET = 2'h0;
    localparam logic [3:0] SERIAL_BITS = 4'h8;
    localparam logic [3:0] PARALLEL_NIBBLES = 4'h2;
    localparam logic [7:0] STOP_CODE = 8'h01;
    typedef enum logic [1:0] {
        RUN = 2'b00,
        ARMED = 2'b01,
        STANDBY = 2'b11
    } power_state_t;
endpackage : standby_pkg

// ### hw/pin_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one clock domain
// Notes: first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ### hw/lcd_ctrl_standby_reset.sv
// Purpose: standby entry/exit and reset initialisation of the LCD controller
// Assumes: RESET_PIN is the active-high pin, sampled on REF_CLK
// Notes: NRST is the internal power-on reset, separate from RESET_PIN
`timescale 1ns/100ps
`default_nettype none
module lcd_ctrl_standby_reset (
    // clock, reset, enable
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic CLK_EN,
    // host pins
    input wire logic RESET_PIN,
    input wire logic CHIP_SELECT_N,
    input wire logic NIBBLE_STROBE_N,
    input wire logic ADDR_ENABLE_STRAP,
    input wire logic PAR_SERIAL_STRAP,
    input wire logic ADDR_STRAP_HI,
    input wire logic ADDR_STRAP_LO,
    input wire logic SINGLE_CHIP,
    // from interface front end, same clock
    input wire logic BYTE_DONE,
    input wire logic [7:0] BYTE_DATA,
    input wire logic CORE_BUSY,
    // busy pin
    output logic BUSY_N_O,
    output logic BUSY_N_OE,
    // status and config
    output logic IN_STANDBY,
    output logic TIMING_CLK_EN,
    output logic PROC_HALT,
    output logic DRIVE_LEVEL_THREE,
    output logic DISPLAY_BLANK,
    output logic MEM_VALID,
    output logic PARALLEL_MODE,
    output logic ADDRESSING_ON,
    output logic [1:0] COMPARE_ADDR,
    output logic CHIP_SELECTED,
    output logic [1:0] PROC_MODE,
    output logic [1:0] POINTER_STEP,
    output logic [6:0] POINTER_VALUE,
    output logic [2:0] MULTIPLEX_FIELD,
    output logic [2:0] FRAME_DIVIDER_FIELD,
    output logic [3:0] XFER_COUNT,
    output logic ADDR_PHASE
);
    logic [3:0] raw_pins;
    logic [3:0] sync_pins;
    logic rst_pin;
    logic cs_n;
    logic strap_ae;
    logic strap_ps;
    logic rst_pin_d;
    logic rst_fall;
    logic cs_n_d;
    logic cs_fall;
    logic cs_rose_in_standby;
    logic exit_by_byte;
    standby_pkg::power_state_t state;
    standby_pkg::power_state_t next_state;

    assign raw_pins = {RESET_PIN, CHIP_SELECT_N, ADDR_ENABLE_STRAP,
                       PAR_SERIAL_STRAP};

    // pins come from the host, outside our clock
    pin_sync #(.WIDTH(4)) u_sync (
        .clk(REF_CLK),
        .rst_n(NRST),
        .ce(CLK_EN),
        .d(raw_pins),
        .q(sync_pins)
    );

    assign rst_pin = sync_pins[3];
    assign cs_n = sync_pins[2];
    assign strap_ae = sync_pins[1];
    assign strap_ps = sync_pins[0];
    assign rst_fall = rst_pin_d && !rst_pin;
    assign cs_fall = cs_n_d && !cs_n;

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_pin_d <= 1'b0;
            // matches the synchroniser's reset value: no false fall
            cs_n_d <= 1'b0;
        end else if (CLK_EN) begin
            rst_pin_d <= rst_pin;
            cs_n_d <= cs_n;
        end
    end

    // byte completion from the front end already marks the 8th shift
    // clock rise in serial mode and the 2nd strobe rise in parallel
    assign exit_by_byte = BYTE_DONE && !ADDR_PHASE;

    // power state machine
    always_comb begin
        next_state = state;
        unique case (state)
            standby_pkg::RUN: begin
                if (BYTE_DONE && BYTE_DATA == standby_pkg::STOP_CODE
                    && !rst_pin) begin
                    next_state = standby_pkg::ARMED;
                end
            end
            standby_pkg::ARMED: begin
                if (!CORE_BUSY) begin
                    next_state = standby_pkg::STANDBY;
                end
            end
            standby_pkg::STANDBY: begin
                // reset high keeps us parked here
                if (rst_fall) begin
                    next_state = standby_pkg::RUN;
                end else if (!rst_pin && exit_by_byte) begin
                    next_state = standby_pkg::RUN;
                end
            end
            default: next_state = standby_pkg::RUN;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state <= standby_pkg::RUN;
        end else if (CLK_EN) begin
            if (rst_pin && state != standby_pkg::STANDBY) begin
                state <= standby_pkg::RUN;
            end else begin
                state <= next_state;
            end
        end
    end

    assign IN_STANDBY = (state == standby_pkg::STANDBY);
    assign TIMING_CLK_EN = CLK_EN && !IN_STANDBY;

    // address byte tracking in serial addressed mode
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            cs_rose_in_standby <= 1'b0;
            ADDR_PHASE <= 1'b0;
        end else if (CLK_EN) begin
            if (!IN_STANDBY) begin
                cs_rose_in_standby <= 1'b0;
                ADDR_PHASE <= 1'b0;
            end else begin
                if (cs_n && !PARALLEL_MODE && ADDRESSING_ON) begin
                    cs_rose_in_standby <= 1'b1;
                end
                if (cs_fall && cs_rose_in_standby) begin
                    ADDR_PHASE <= 1'b1;
                end else if (BYTE_DONE && ADDR_PHASE) begin
                    ADDR_PHASE <= 1'b0;
                end
            end
        end
    end

    // interface selection caught at reset release
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            PARALLEL_MODE <= 1'b0;
            ADDRESSING_ON <= 1'b0;
        end else if (CLK_EN && rst_fall) begin
            PARALLEL_MODE <= strap_ps;
            ADDRESSING_ON <= strap_ps || strap_ae;
        end
    end

    // address compare value and selection
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            COMPARE_ADDR <= standby_pkg::COMPARE_RESET;
        end else if (CLK_EN) begin
            if (rst_pin) begin
                COMPARE_ADDR <= standby_pkg::COMPARE_RESET;
            end else if (BYTE_DONE && ADDR_PHASE) begin
                COMPARE_ADDR <= BYTE_DATA[1:0];
            end
        end
    end

    assign CHIP_SELECTED = ({ADDR_STRAP_HI, ADDR_STRAP_LO} == COMPARE_ADDR)
                           || SINGLE_CHIP;

    // busy pin: driven for the matching selected chip; low under reset, while busy or armed
    always_comb begin
        if (rst_pin) begin
            BUSY_N_O = 1'b0;
            BUSY_N_OE = !cs_n && CHIP_SELECTED;
        end else begin
            BUSY_N_O = !(CORE_BUSY || state == standby_pkg::ARMED);
            BUSY_N_OE = !cs_n && CHIP_SELECTED;
        end
    end

    assign PROC_HALT = rst_pin;
    assign DRIVE_LEVEL_THREE = rst_pin;

    // processing mode and pointer step
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            PROC_MODE <= standby_pkg::MODE_WRITE;
            POINTER_STEP <= standby_pkg::STEP_INC;
        end else if (CLK_EN) begin
            if (rst_pin || next_state == standby_pkg::STANDBY) begin
                PROC_MODE <= standby_pkg::MODE_WRITE;
                POINTER_STEP <= standby_pkg::STEP_INC;
            end
        end
    end

    // display mode fields, pointer and transfer counter
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            POINTER_VALUE <= standby_pkg::POINTER_RESET;
            MULTIPLEX_FIELD <= standby_pkg::MULTIPLEX_RESET;
            FRAME_DIVIDER_FIELD <= standby_pkg::FRAME_DIV_RESET;
            XFER_COUNT <= 4'h0;
        end else if (CLK_EN) begin
            if (rst_pin) begin
                POINTER_VALUE <= standby_pkg::POINTER_RESET;
                MULTIPLEX_FIELD <= standby_pkg::MULTIPLEX_RESET;
                FRAME_DIVIDER_FIELD <= standby_pkg::FRAME_DIV_RESET;
                XFER_COUNT <= 4'h0;
            end else if (BYTE_DONE) begin
                XFER_COUNT <= XFER_COUNT + 4'h1;
            end
        end
    end

    // display stays blank after reset; nothing in this block unblanks it
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            DISPLAY_BLANK <= 1'b1;
            MEM_VALID <= 1'b0;
        end else if (CLK_EN) begin
            if (rst_pin) begin
                DISPLAY_BLANK <= 1'b1;
                if (!IN_STANDBY) begin
                    MEM_VALID <= 1'b0;
                end
            end else if (BYTE_DONE && !IN_STANDBY) begin
                MEM_VALID <= 1'b1;
            end
        end
    end
endmodule : lcd_ctrl_standby_reset
`default_nettype wire

// ### verification/lcd_ctrl_standby_reset_asserts.sv
// Purpose: port-level checks of standby entry, exit and reset state
// Assumes: CLK_EN held high, static straps around reset
// Notes: bound to every instance of the sequencer
`timescale 1ns/100ps
`default_nettype none
module lcd_ctrl_standby_reset_asserts (
    // clock, reset and host side
    input wire logic REF_CLK, NRST, CLK_EN, RESET_PIN,
    input wire logic CHIP_SELECT_N, ADDR_STRAP_HI, ADDR_STRAP_LO,
    input wire logic SINGLE_CHIP, BYTE_DONE, CORE_BUSY,
    // outputs under watch
    input wire logic BUSY_N_O, BUSY_N_OE, IN_STANDBY, TIMING_CLK_EN,
    input wire logic PROC_HALT, DRIVE_LEVEL_THREE, ADDR_PHASE,
    input wire logic [1:0] PROC_MODE, POINTER_STEP, COMPARE_ADDR,
    input wire logic [6:0] POINTER_VALUE,
    input wire logic [2:0] MULTIPLEX_FIELD, FRAME_DIVIDER_FIELD,
    input wire logic [3:0] XFER_COUNT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // chip answers as address zero
    wire logic strap0 = SINGLE_CHIP || !(ADDR_STRAP_HI || ADDR_STRAP_LO);
    property p_enter;
        $rose(IN_STANDBY) |-> !$past(CORE_BUSY);
    endproperty
    a_enter: assert property (p_enter) else $error("early entry");
    property p_gate;
        IN_STANDBY |-> !TIMING_CLK_EN;
    endproperty
    a_gate: assert property (p_gate) else $error("clock not gated");
    property p_force;
        $rose(IN_STANDBY) |-> PROC_MODE == standby_pkg::MODE_WRITE
            && POINTER_STEP == standby_pkg::STEP_INC;
    endproperty
    a_force: assert property (p_force) else $error("mode kept");
    // ignore sampled bytes near a reset edge
    property p_exit;
        IN_STANDBY && BYTE_DONE && !ADDR_PHASE && !PROC_HALT && !RESET_PIN
            |=> !IN_STANDBY;
    endproperty
    a_exit: assert property (p_exit) else $error("no exit");
    property p_stay;
        IN_STANDBY && PROC_HALT ##1 PROC_HALT |-> IN_STANDBY;
    endproperty
    a_stay: assert property (p_stay) else $error("left");
    property p_init;
        PROC_HALT ##1 PROC_HALT |-> POINTER_VALUE == 7'h00
            && MULTIPLEX_FIELD == 3'h0 && FRAME_DIVIDER_FIELD == 3'h0
            && XFER_COUNT == 4'h0 && COMPARE_ADDR == 2'h0
            && PROC_MODE == standby_pkg::MODE_WRITE && POINTER_STEP == 2'h0;
    endproperty
    a_init: assert property (p_init) else $error("bad init");
    property p_level;
        PROC_HALT |-> DRIVE_LEVEL_THREE;
    endproperty
    a_level: assert property (p_level) else $error("no dc");
    property p_busy_sel;
        (PROC_HALT && !CHIP_SELECT_N && strap0)[*3] |-> BUSY_N_OE && !BUSY_N_O;
    endproperty
    a_busy_sel: assert property (p_busy_sel) else $error("busy");
    property p_busy_off;
        (PROC_HALT && (CHIP_SELECT_N || !strap0))[*3] |-> !BUSY_N_OE;
    endproperty
    a_busy_off: assert property (p_busy_off) else $error("driven");
endmodule : lcd_ctrl_standby_reset_asserts
bind lcd_ctrl_standby_reset lcd_ctrl_standby_reset_asserts chk (.*);
`default_nettype wire

// ### verification/host_model.sv
// Purpose: host cpu side: bytes, select and reset pin
// Assumes: byte framing already reduced to a one-cycle pulse
// Notes: clock is never stopped, so no stop-delay is needed
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // clock and busy pin
    input wire logic clk,
    input wire logic busy_n,
    // pins driven
    output logic reset_pin,
    output logic cs_n,
    output logic byte_done,
    output logic [7:0] byte_data
);
    logic lcd_ref_level_five;
    initial begin
        reset_pin = 1'b0;
        cs_n = 1'b0;
        byte_done = 1'b0;
        byte_data = 8'h00;
        lcd_ref_level_five = 1'b0;
    end
    task automatic send(input logic [7:0] b);
        @(negedge clk);
        if (b === standby_pkg::STOP_CODE) lcd_ref_level_five = 1'b1;
        byte_data = b;
        byte_done = 1'b1;
        @(negedge clk);
        byte_done = 1'b0;
        byte_data = ~b;
        repeat (4) @(negedge clk);
    endtask : send
    task automatic set_pins(input logic r, input logic c);
        int n = 0;
        while (r && busy_n !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        reset_pin = r;
        cs_n = c;
        repeat (5) @(negedge clk);
    endtask : set_pins
endmodule : host_model
`default_nettype wire

// ### verification/lcd_ctrl_standby_reset_tb_top.sv
// Purpose: directed scenarios for standby and reset sequencing
// Assumes: byte front end modelled by the host pulse
// Notes: scenarios run in order; memory flag relies on it
`timescale 1ns/100ps
`default_nettype none
module lcd_ctrl_standby_reset_tb_top;
    logic REF_CLK = 1'b0, NRST = 1'b0, CLK_EN = 1'b1, CORE_BUSY = 1'b0;
    logic NIBBLE_STROBE_N = 1'b1, ADDR_ENABLE_STRAP = 1'b0;
    logic PAR_SERIAL_STRAP = 1'b0, ADDR_STRAP_HI = 1'b0;
    logic ADDR_STRAP_LO = 1'b0, SINGLE_CHIP = 1'b0;
    logic RESET_PIN, CHIP_SELECT_N, BYTE_DONE, BUSY_N_O, BUSY_N_OE;
    logic IN_STANDBY, TIMING_CLK_EN, PROC_HALT, DRIVE_LEVEL_THREE;
    logic DISPLAY_BLANK, MEM_VALID, PARALLEL_MODE, ADDRESSING_ON;
    logic CHIP_SELECTED, ADDR_PHASE;
    logic [7:0] BYTE_DATA;
    logic [1:0] COMPARE_ADDR, PROC_MODE, POINTER_STEP;
    logic [6:0] POINTER_VALUE;
    logic [2:0] MULTIPLEX_FIELD, FRAME_DIVIDER_FIELD;
    logic [3:0] XFER_COUNT;
    int fails = 0, num_checks = 0;
    // pull-up on the busy pin
    wire logic busy_line = BUSY_N_OE ? BUSY_N_O : 1'b1;
    always #50 REF_CLK = ~REF_CLK;
    lcd_ctrl_standby_reset dut (.*);
    host_model host (.clk(REF_CLK), .busy_n(busy_line), .reset_pin(RESET_PIN),
        .cs_n(CHIP_SELECT_N), .byte_done(BYTE_DONE), .byte_data(BYTE_DATA));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic enter_standby();
        CORE_BUSY = 1'b1;
        host.send(standby_pkg::STOP_CODE);
        chk(host.lcd_ref_level_five, 8'h01);
        chk(IN_STANDBY, 8'h00);
        CORE_BUSY = 1'b0;
        repeat (3) @(negedge REF_CLK);
        chk(IN_STANDBY, 8'h01);
        chk(TIMING_CLK_EN, 8'h00);
        chk(POINTER_STEP, 8'h00);
        chk(PROC_MODE, standby_pkg::MODE_WRITE);
    endtask : enter_standby
    task automatic s_byte_exit();
        enter_standby();
        host.send(8'h55);
        chk(IN_STANDBY, 8'h00);
        chk(TIMING_CLK_EN, 8'h01);
    endtask : s_byte_exit
    task automatic s_reset_exit();
        enter_standby();
        host.set_pins(1'b1, 1'b0);
        chk(IN_STANDBY, 8'h01);
        chk(DRIVE_LEVEL_THREE, 8'h01);
        chk(PROC_HALT, 8'h01);
        chk(XFER_COUNT, 8'h00);
        chk(POINTER_VALUE, 8'h00);
        chk(MULTIPLEX_FIELD, 8'h00);
        chk(FRAME_DIVIDER_FIELD, 8'h00);
        chk(COMPARE_ADDR, 8'h00);
        host.send(8'h22);
        chk(IN_STANDBY, 8'h01);
        PAR_SERIAL_STRAP = 1'b1;
        host.set_pins(1'b0, 1'b0);
        chk(IN_STANDBY, 8'h00);
        chk(MEM_VALID, 8'h01);
        chk(PARALLEL_MODE, 8'h01);
        chk(DISPLAY_BLANK, 8'h01);
        chk(CHIP_SELECTED, 8'h01);
        enter_standby();
        host.send(8'h33);
        chk(IN_STANDBY, 8'h00);
    endtask : s_reset_exit
    task automatic s_addr_exit();
        PAR_SERIAL_STRAP = 1'b0;
        ADDR_ENABLE_STRAP = 1'b1;
        host.set_pins(1'b1, 1'b1);
        chk(BUSY_N_OE, 8'h00);
        chk(MEM_VALID, 8'h00);
        host.set_pins(1'b1, 1'b0);
        chk(busy_line, 8'h00);
        ADDR_STRAP_HI = 1'b1;
        repeat (4) @(negedge REF_CLK);
        chk(BUSY_N_OE, 8'h00);
        ADDR_STRAP_HI = 1'b0;
        host.set_pins(1'b0, 1'b0);
        chk(ADDRESSING_ON, 8'h01);
        chk(PARALLEL_MODE, 8'h00);
        enter_standby();
        host.set_pins(1'b0, 1'b1);
        host.set_pins(1'b0, 1'b0);
        host.send(8'h00);
        chk(IN_STANDBY, 8'h01);
        host.send(8'h44);
        chk(IN_STANDBY, 8'h00);
    endtask : s_addr_exit
    initial begin
        repeat (6) @(negedge REF_CLK);
        NRST = 1'b1;
        repeat (2) @(negedge REF_CLK);
        s_byte_exit();
        s_reset_exit();
        s_addr_exit();
        conclude();
    end
    // scenarios need about 120 cycles; 3000 cycles, 25 times that, is a hang
    initial begin
        #300000;
        fails++;
        conclude();
    end
endmodule : lcd_ctrl_standby_reset_tb_top
`default_nettype wire
